// ==== rtl/pmc_params.svh ====
// Purpose: offsets, field positions, reset values and timing for the power management control
// Assumes: 100 MHz clk_i, APB with 12-bit byte addresses
// Notes: the package holds the types
//
// Overview of operation
// - the control register answers reads in every power state.
// - self-clearing two-bit field selects full power, wake detect or energy detect.
// - any write to the byte order test register wakes a sleeping device.
// - phy reset bit holds the phy in reset at least 100us, then self-clears.
// - writes to the phy reset bit are ignored while it reads high.
// - enabled wake frame event drives pin if enabled, interrupt always.
// - enabled energy event drives pin if enabled, interrupt always.
// - wake cause reads none, energy, frame, or both events.
// - wake cause bits clear on write one, only once their source is clear.
// - wake cause bits cannot clear until full power with ready set.
// - pulse select gives a 50ms pin pulse, else a continuous level.
// - pin deasserts when causes or the relevant enables are cleared.
// - in push-pull the polarity bit selects active high or active low.
// - pin enable gates only the pin, never the interrupt.
// - read-only ready flag sets once the device has settled.
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMC_OFF_CTRL 12'h084
`define PMC_OFF_WAKE_POKE 12'h064

// ----------------------------------------
// field positions
// ----------------------------------------
`define PMC_F_READY 0
`define PMC_F_PIN_EN 1
`define PMC_F_POL 2
`define PMC_F_PULSE 3
`define PMC_F_CAUSE_LO 4
`define PMC_F_CAUSE_HI 5
`define PMC_F_TYPE 6
`define PMC_F_ENERGY_EN 8
`define PMC_F_WF_EN 9
`define PMC_F_PHY_RESET 10
`define PMC_F_MODE_LO 12
`define PMC_F_MODE_HI 13

// ----------------------------------------
// reset values
// ----------------------------------------
`define PMC_RST_BIT 1'b0
`define PMC_RST_CAUSE 2'b00

// ----------------------------------------
// timing
// ----------------------------------------
`define PMC_CLK_MHZ 100
`define PMC_PHY_RESET_US 100
`define PMC_PULSE_MS 50
`define PMC_PHY_RESET_CYC (`PMC_PHY_RESET_US * `PMC_CLK_MHZ)
`define PMC_PULSE_CYC (`PMC_PULSE_MS * 1000 * `PMC_CLK_MHZ)
`define PMC_SETTLE_CYC 16

`endif

// ==== rtl/pmc_pkg.sv ====
// Purpose: types of the power management control
// Assumes: nothing
// Notes: offsets and timing live in pmc_params.svh
package pmc_pkg;

  // ----------------------------------------
  // sequencer states, gray along run-sleep-settle
  // ----------------------------------------
  typedef enum logic [1:0] {
    PMC_ST_RUN = 2'b00,
    PMC_ST_SLEEP = 2'b01,
    PMC_ST_SETTLE = 2'b11
  } pmc_fsm_t;

  // ----------------------------------------
  // power state field codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PMC_PS_FULL_POWER_STATE = 2'b00,
    PMC_PS_WAKE_DETECT_STATE = 2'b01,
    PMC_PS_ENERGY_DETECT_STATE = 2'b10,
    PMC_PS_RESERVED = 2'b11
  } pmc_pstate_t;

endpackage

// ==== rtl/pmc_timer.sv ====
// Purpose: one-shot cycle timer, busy for exactly CYCLES cycles after start
// Assumes: start_i is a one-cycle pulse on clk_i
// Notes: a start while busy is ignored; abort_i ends the run with no done
`timescale 1ns/100ps
module pmc_timer #(
  parameter int CYCLES = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  output logic busy_o,
  output logic done_o
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_q;
  logic busy_q;

  wire last_w = busy_q & (cnt_q == W'(1));
  wire load_w = start_i & ~busy_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (load_w) begin
      cnt_q <= W'(CYCLES);
      busy_q <= 1'b1;
    end else if (abort_i | last_w) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign busy_o = busy_q;
  assign done_o = last_w & ~abort_i;

endmodule

// ==== rtl/pmc_ctrl.sv ====
// Purpose: power management control register with wake pin, phy reset and ready sequencing
// Assumes: event inputs are levels from detectors on clk_i; APB master on clk_i
// Notes: one wait state on every APB access so that read data comes from a flop
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "pmc_params.svh"
module pmc_ctrl #(
  parameter int PHY_RESET_CYCLES = `PMC_PHY_RESET_CYC,
  parameter int PULSE_CYCLES = `PMC_PULSE_CYC,
  parameter int SETTLE_CYCLES = `PMC_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic energy_detect_i,
  input wire logic wake_frame_i,
  output logic phy_reset_o,
  output pmc_pkg::pmc_pstate_t power_state_o,
  output logic device_ready_o,
  output logic wake_event_interrupt_o,
  output logic wake_event_pin_o,
  output logic wake_event_pin_oe_o
);
  import pmc_pkg::*;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // ----------------------------------------
  // state
  // ----------------------------------------
  pmc_fsm_t st_q;
  pmc_fsm_t st_d;
  pmc_pstate_t mode_q;
  pmc_pstate_t mode_d;
  logic ready_q;
  logic ready_d;
  logic read_seen_q;
  logic read_seen_d;
  logic boot_q;
  logic phy_q;
  logic wf_en_q;
  logic energy_en_q;
  logic type_q;
  logic pulse_q;
  logic pol_q;
  logic pin_en_q;
  logic [1:0] cause_q;
  logic [1:0] cause_d;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic pin_act_q;
  logic pin_q;
  logic pin_oe_q;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire acc_w = psel_i & penable_i;
  wire first_w = acc_w & ~pready_q;
  wire done_w = acc_w & pready_q;
  wire hit_ctrl_w = (paddr_i == `PMC_OFF_CTRL);
  wire hit_poke_w = (paddr_i == `PMC_OFF_WAKE_POKE);
  wire hit_w = hit_ctrl_w | hit_poke_w;
  wire lane0_w = pstrb_i[0];
  wire lane1_w = pstrb_i[1];
  wire rd_done_w = done_w & ~pwrite_i;
  wire poke_wr_w = done_w & pwrite_i & hit_poke_w;
  // control writes count only once ready and after a read; other control writes are dropped silently
  wire wr_ok_w = done_w & pwrite_i & hit_ctrl_w & ready_q & read_seen_q;
  wire wr_hi_w = wr_ok_w & lane1_w;
  wire wr_lo_w = wr_ok_w & lane0_w;
  wire [1:0] w_mode_w = pwdata_i[`PMC_F_MODE_HI:`PMC_F_MODE_LO];
  wire mode_ok_w = (w_mode_w == PMC_PS_WAKE_DETECT_STATE) |
                   (w_mode_w == PMC_PS_ENERGY_DETECT_STATE);

  // register image; the control register is always served, whatever the state
  wire [31:0] ctrl_rd_w = {18'h00000, mode_q, 1'b0, phy_q, wf_en_q, energy_en_q, 1'b0,
                           type_q, cause_q, pulse_q, pol_q, pin_en_q, ready_q};
  wire [31:0] rd_w = hit_ctrl_w ? ctrl_rd_w : 32'h00000000;

  // ----------------------------------------
  // wake causes
  // ----------------------------------------
  wire [1:0] src_w = {wake_frame_i, energy_detect_i};
  wire [1:0] set_w = src_w & {wf_en_q, energy_en_q};
  wire clr_ok_w = wr_lo_w & (st_q == PMC_ST_RUN);
  wire [1:0] clr_w = {2{clr_ok_w}} & pwdata_i[`PMC_F_CAUSE_HI:`PMC_F_CAUSE_LO] &
                     ~src_w;
  wire en_cause_w = |(cause_q & {wf_en_q, energy_en_q});

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire enter_w = wr_hi_w & mode_ok_w & (st_q == PMC_ST_RUN);
  wire wake_w = (st_q == PMC_ST_SLEEP) & (poke_wr_w | (|set_w));
  wire settle_done_w;
  wire phy_start_w = wr_hi_w & pwdata_i[`PMC_F_PHY_RESET] & ~phy_q;
  wire phy_done_w;
  wire pulse_busy_w;
  wire pulse_start_w = pulse_q & (|(set_w & ~cause_q));

  pmc_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .start_i(boot_q | wake_w),
    .abort_i(1'b0),
    .busy_o(),
    .done_o(settle_done_w)
  );

  pmc_timer #(
    .CYCLES(PHY_RESET_CYCLES)
  ) u_phy (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .start_i(phy_start_w),
    .abort_i(1'b0),
    .busy_o(),
    .done_o(phy_done_w)
  );

  // the pulse stops early once no cause with its enable set remains
  pmc_timer #(
    .CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .start_i(pulse_start_w),
    .abort_i(~en_cause_w),
    .busy_o(pulse_busy_w),
    .done_o()
  );

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    ready_d = ready_q;
    read_seen_d = read_seen_q | rd_done_w;
    case (st_q)
      PMC_ST_RUN: begin
        if (enter_w) begin
          st_d = PMC_ST_SLEEP;
          mode_d = pmc_pstate_t'(w_mode_w);
          ready_d = 1'b0;
        end
      end
      PMC_ST_SLEEP: begin
        if (wake_w) begin
          st_d = PMC_ST_SETTLE;
          mode_d = PMC_PS_FULL_POWER_STATE;
          read_seen_d = rd_done_w;
        end
      end
      PMC_ST_SETTLE: begin
        if (settle_done_w) begin
          st_d = PMC_ST_RUN;
          ready_d = 1'b1;
        end
      end
      default: begin
        st_d = PMC_ST_SETTLE;
        ready_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= PMC_ST_SETTLE;
      mode_q <= PMC_PS_FULL_POWER_STATE;
      ready_q <= `PMC_RST_BIT;
      read_seen_q <= `PMC_RST_BIT;
      boot_q <= 1'b1;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      ready_q <= ready_d;
      read_seen_q <= read_seen_d;
      boot_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // control bits
  // ----------------------------------------
  assign cause_d = set_w | (cause_q & ~clr_w);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phy_q <= `PMC_RST_BIT;
      cause_q <= `PMC_RST_CAUSE;
    end else begin
      phy_q <= phy_start_w | (phy_q & ~phy_done_w);
      cause_q <= cause_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wf_en_q <= `PMC_RST_BIT;
      energy_en_q <= `PMC_RST_BIT;
    end else if (wr_hi_w) begin
      wf_en_q <= pwdata_i[`PMC_F_WF_EN];
      energy_en_q <= pwdata_i[`PMC_F_ENERGY_EN];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      type_q <= `PMC_RST_BIT;
      pulse_q <= `PMC_RST_BIT;
      pol_q <= `PMC_RST_BIT;
      pin_en_q <= `PMC_RST_BIT;
    end else if (wr_lo_w) begin
      type_q <= pwdata_i[`PMC_F_TYPE];
      pulse_q <= pwdata_i[`PMC_F_PULSE];
      pol_q <= pwdata_i[`PMC_F_POL];
      pin_en_q <= pwdata_i[`PMC_F_PIN_EN];
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= first_w;
      pslverr_q <= first_w & ~hit_w;
      prdata_q <= first_w ? rd_w : prdata_q;
    end
  end

  // ----------------------------------------
  // wake pin and interrupt
  // ----------------------------------------
  // interrupt ignores the pin enable; the pin follows pulse or level choice
  wire irq_d_w = en_cause_w;
  wire pin_act_d_w = pin_en_q & en_cause_w & (~pulse_q | pulse_busy_w);
  // open drain only sinks, so polarity has no meaning there
  wire pin_d_w = type_q & (pol_q ? pin_act_d_w : ~pin_act_d_w);
  wire pin_oe_d_w = type_q | pin_act_d_w;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_q <= 1'b0;
      pin_act_q <= 1'b0;
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      irq_q <= irq_d_w;
      pin_act_q <= pin_act_d_w;
      pin_q <= pin_d_w;
      pin_oe_q <= pin_oe_d_w;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign phy_reset_o = phy_q;
  assign power_state_o = mode_q;
  assign device_ready_o = ready_q;
  assign wake_event_interrupt_o = irq_q;
  assign wake_event_pin_o = pin_q;
  assign wake_event_pin_oe_o = pin_oe_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [31:0] phy_cnt_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phy_cnt_q <= 32'h00000000;
    end else begin
      phy_cnt_q <= phy_q ? phy_cnt_q + 32'h00000001 : 32'h00000000;
    end
  end

  AST_READ_ALWAYS: assert property (
    first_w && !pwrite_i && hit_ctrl_w |=> pready_o && !pslverr_o)
    else $error("control read not answered");
  AST_NO_RSVD_MODE: assert property (
    power_state_o != PMC_PS_RESERVED)
    else $error("reserved power state entered");
  AST_WAKE_POKE: assert property (
    poke_wr_w && st_q == PMC_ST_SLEEP |=> st_q == PMC_ST_SETTLE &&
    power_state_o == PMC_PS_FULL_POWER_STATE && !device_ready_o)
    else $error("poke did not wake");
  AST_PHY_MIN: assert property (
    $fell(phy_reset_o) |-> phy_cnt_q >= 32'(PHY_RESET_CYCLES))
    else $error("phy reset too short");
  AST_PHY_MAX: assert property (
    phy_cnt_q <= 32'(PHY_RESET_CYCLES))
    else $error("phy reset retriggered");
  AST_IRQ_FRAME: assert property (
    cause_q[1] && wf_en_q |=> wake_event_interrupt_o)
    else $error("frame event lost interrupt");
  AST_IRQ_ENERGY: assert property (
    cause_q[0] && energy_en_q |=> wake_event_interrupt_o)
    else $error("energy event lost interrupt");
  AST_OPEN_DRAIN: assert property (
    $past(!type_q) |-> !wake_event_pin_o && (wake_event_pin_oe_o == pin_act_q))
    else $error("open drain drives high");
  AST_CAUSE_SET: assert property (
    wake_frame_i && wf_en_q ##0 energy_detect_i && energy_en_q |=> cause_q == 2'b11)
    else $error("multiple causes not recorded");
  AST_CLR_BLOCKED: assert property (
    cause_q[0] && energy_detect_i |=> cause_q[0])
    else $error("cause cleared with source active");
  AST_CLR_NOT_READY: assert property (
    !device_ready_o |=> ($past(cause_q) & ~cause_q) == 2'b00)
    else $error("cause cleared before ready");
  AST_LEVEL: assert property (
    pin_en_q && en_cause_w && !pulse_q |=> pin_act_q)
    else $error("level output missing");
  AST_PIN_RELEASE: assert property (
    !en_cause_w |=> !pin_act_q && !wake_event_interrupt_o)
    else $error("pin not released");
  AST_POLARITY: assert property (
    $past(type_q && pol_q) |-> wake_event_pin_o == pin_act_q && wake_event_pin_oe_o)
    else $error("push pull polarity wrong");
  AST_PIN_GATE: assert property (
    !pin_en_q |=> !pin_act_q)
    else $error("pin driven while disabled");
  AST_READY: assert property (
    st_q != PMC_ST_RUN |-> !device_ready_o)
    else $error("ready before settled");

endmodule

// ==== tb/pmc_host_model.sv ====
// Purpose: APB host that issues one transfer at a time
// Assumes: clk_i at 100 MHz
// Notes: waits for pready_i without assuming a wait count
`timescale 1ns/100ps
module pmc_host_model (
  input wire logic clk_i,
  input wire logic pready_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
  end

  // request held steady until pready is sampled high
  // a slave that never answers is left to the bench watchdog, which fails the run
  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d);
    if (we && a == 12'h084 && d[13:12] == 2'b11) return;
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= we;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the power management control
// Assumes: short counts so pulses and phy reset fit a short run
// Notes: read results are checked from a queue by a monitor
`timescale 1ns/100ps
`include "pmc_params.svh"
`define CHK(nm, e, g) \
  samples_checked++; \
  if ((g) !== (e)) begin \
    $display("mismatch %s exp %h got %h", nm, e, g); \
    num_errors++; \
  end
module tb_top;
  import pmc_pkg::*;
  logic clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, ed, wf;
  logic phy_hold, rdy, irq, pin, oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfg, r;
  logic [32:0] exp_v;
  logic [32:0] exp_q[$];
  pmc_pstate_t pstate;
  int num_errors, samples_checked, seed, run, last_run, i;

  pmc_ctrl #(.PHY_RESET_CYCLES(20), .PULSE_CYCLES(30), .SETTLE_CYCLES(4)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .energy_detect_i(ed), .wake_frame_i(wf), .phy_reset_o(phy_hold),
    .power_state_o(pstate), .device_ready_o(rdy), .wake_event_interrupt_o(irq),
    .wake_event_pin_o(pin), .wake_event_pin_oe_o(oe));

  pmc_host_model host_u (.clk_i(clk_i), .pready_i(pready), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (phy_hold === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
  end

  always @(posedge clk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("mismatch read exp none got %h", prdata);
      end else begin
        exp_v = exp_q.pop_front();
        `CHK("read", exp_v, {pslverr, prdata})
      end
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    #1;
    `CHK("ready", 1'b1, rdy)
  endtask

  // open drain ignores polarity, so only enable follows the event
  function automatic logic [1:0] pin_exp(input logic act, input logic ty, input logic pol);
    return {ty ? 1'b1 : act, ty ? (pol ? act : ~act) : 1'b0};
  endfunction

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    $display("mismatch run exp done got timeout");
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 62;
    num_errors = 0;
    samples_checked = 0;
    arst_n_i = 1'b0;
    ed = 1'b0;
    wf = 1'b0;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wait_ready();
    wr(`PMC_OFF_CTRL, 32'h2);
    rd(`PMC_OFF_CTRL, 33'h1);
    r = $random(seed);
    rd(12'h200 | {4'h0, r[7:2], 2'b00}, 33'h1_0000_0000);
    wr(`PMC_OFF_CTRL, 32'h400);
    cyc(2);
    `CHK("phy_reset", 1'b1, phy_hold)
    rd(`PMC_OFF_CTRL, 33'h401);
    wr(`PMC_OFF_CTRL, 32'h400);
    cyc(30);
    `CHK("phy_run", 20, last_run)
    for (i = 0; i < 8; i++) begin
      cfg = 32'h100 | {25'h0, i[2], 3'h0, i[1], i[0], 1'b0};
      wr(`PMC_OFF_CTRL, cfg);
      @(posedge clk_i);
      ed <= 1'b1;
      cyc(3);
      `CHK("irq", 1'b1, irq)
      `CHK("pin", pin_exp(i[0], i[2], i[1]), {oe, pin})
      rd(`PMC_OFF_CTRL, {1'b0, cfg | 32'h11});
      wr(`PMC_OFF_CTRL, cfg | 32'h10);
      rd(`PMC_OFF_CTRL, {1'b0, cfg | 32'h11});
      @(posedge clk_i);
      ed <= 1'b0;
      wr(`PMC_OFF_CTRL, cfg | 32'h10);
      cyc(3);
      `CHK("irq_clr", 1'b0, irq)
      `CHK("pin_clr", pin_exp(1'b0, i[2], i[1]), {oe, pin})
    end
    wr(`PMC_OFF_CTRL, 32'h34E);
    @(posedge clk_i);
    wf <= 1'b1;
    cyc(5);
    `CHK("pulse_on", 1'b1, pin)
    @(posedge clk_i);
    ed <= 1'b1;
    rd(`PMC_OFF_CTRL, 33'h37F);
    cyc(40);
    `CHK("pulse_off", 1'b0, pin)
    `CHK("irq_both", 1'b1, irq)
    @(posedge clk_i);
    wf <= 1'b0;
    ed <= 1'b0;
    wr(`PMC_OFF_CTRL, 32'h30);
    rd(`PMC_OFF_CTRL, 33'h1);
    wr(`PMC_OFF_CTRL, 32'h1100);
    cyc(1);
    `CHK("state_wake_detect", PMC_PS_WAKE_DETECT_STATE, pstate)
    `CHK("ready_wake_detect", 1'b0, rdy)
    rd(`PMC_OFF_CTRL, 33'h1100);
    wr(`PMC_OFF_WAKE_POKE, $random(seed));
    cyc(1);
    `CHK("state_wake", PMC_PS_FULL_POWER_STATE, pstate)
    wait_ready();
    rd(`PMC_OFF_CTRL, 33'h101);
    wr(`PMC_OFF_CTRL, 32'h2100);
    cyc(1);
    `CHK("state_energy_detect", PMC_PS_ENERGY_DETECT_STATE, pstate)
    @(posedge clk_i);
    ed <= 1'b1;
    wait_ready();
    `CHK("state_ed", PMC_PS_FULL_POWER_STATE, pstate)
    rd(`PMC_OFF_CTRL, 33'h111);
    @(posedge clk_i);
    ed <= 1'b0;
    wr(`PMC_OFF_CTRL, 32'h110);
    rd(`PMC_OFF_CTRL, 33'h101);
    tally_and_finish();
  end
endmodule
